// File: pkg/asrte_pkg.sv
/*
  Shared constants and carrier types for the asynchronous serial engine.
  Assumes a single 20 MHz system clock; all slower rates are enable pulses.
*/
`default_nettype none
package asrte_pkg;
  // Base clock choices (external tick or a divide of the system clock)
  localparam logic [1:0] ASRTE_SRC_EXT     = 2'h0;
  localparam logic [1:0] ASRTE_SRC_DIV4    = 2'h1;
  localparam logic [1:0] ASRTE_SRC_DIV16   = 2'h2;
  localparam logic [1:0] ASRTE_SRC_DIV64   = 2'h3;
  localparam int         ASRTE_PRE_W       = 6;
  localparam logic [5:0] ASRTE_PRE_MASK4   = 6'h03;
  localparam logic [5:0] ASRTE_PRE_MASK16  = 6'h0F;
  localparam logic [5:0] ASRTE_PRE_MASK64  = 6'h3F;
  // Divisor field
  localparam int         ASRTE_DIV_W       = 5;
  localparam logic [4:0] ASRTE_DIV_MIN     = 5'h08;
  localparam logic [4:0] ASRTE_DIV_RESET   = 5'h1F;
  // Parity modes
  localparam logic [1:0] ASRTE_PAR_NONE    = 2'h0;
  localparam logic [1:0] ASRTE_PAR_ZERO    = 2'h1;
  localparam logic [1:0] ASRTE_PAR_ODD     = 2'h2;
  localparam logic [1:0] ASRTE_PAR_EVEN    = 2'h3;
  // Frame geometry
  localparam int         ASRTE_DATA_W      = 8;
  localparam logic [3:0] ASRTE_LEN8        = 4'h8;
  localparam logic [3:0] ASRTE_LEN7        = 4'h7;
  localparam int         ASRTE_ARM_CYC     = 2;

  // Operating mode register contents
  typedef struct packed {
    logic       powerOn;
    logic       txEnable;
    logic       rxEnable;
    logic [1:0] parityMode;
    logic       charLen8;
    logic       twoStop;
  } asrte_mode_s;

  // Receive error status flags
  typedef struct packed {
    logic parityErr;
    logic framingErr;
    logic overrunErr;
  } asrte_err_s;

  // Received word with its errors
  typedef struct packed {
    logic [7:0] data;
    asrte_err_s err;
  } asrte_rxword_s;
endpackage
`default_nettype wire

// File: src/asrte_skid_buf.sv
/*
  Two-entry valid/ready buffer for received words.
  Assumes one clock and asynchronous active-low reset.
*/
`timescale 1ns/1ps
`default_nettype none
module asrte_skid_buf
#(
  parameter int WIDTH = 11
)
(
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rstn,
  input  wire logic             clr,
  // Fill side
  input  wire logic             inValid,
  output logic                  inReady,
  input  wire logic [WIDTH-1:0] inData,
  // Drain side
  output logic                  outValid,
  input  wire logic             outReady,
  output logic [WIDTH-1:0]      outData
);
  logic [WIDTH-1:0] slot_r [2];   // Storage
  logic             wrPtr_r;      // Write slot
  logic             rdPtr_r;      // Read slot
  logic [1:0]       count_r;      // Occupancy
  logic             push;
  logic             pop;

  assign push     = inValid && inReady;
  assign pop      = outValid && outReady;
  assign inReady  = (count_r != 2'h2);
  assign outValid = (count_r != 2'h0);
  assign outData  = slot_r[rdPtr_r];

  // Pointers and occupancy; clear empties the buffer
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      wrPtr_r <= 1'b0;
      rdPtr_r <= 1'b0;
      count_r <= 2'h0;
    end
    else if (clr)
    begin
      wrPtr_r <= 1'b0;
      rdPtr_r <= 1'b0;
      count_r <= 2'h0;
    end
    else
    begin
      if (push)
        wrPtr_r <= ~wrPtr_r;
      if (pop)
        rdPtr_r <= ~rdPtr_r;
      count_r <= count_r + {1'b0, push} - {1'b0, pop};
    end
  end

  // Data slots
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      slot_r[0] <= '0;
      slot_r[1] <= '0;
    end
    else if (push)
      slot_r[wrPtr_r] <= inData;
  end
endmodule // asrte_skid_buf
`default_nettype wire

// File: src/asrte_serial_engine.sv
/*
  Full-duplex asynchronous serial transmitter and receiver with prescaler,
  separate 5-bit baud counters, noise filter and receive error flags.
  Assumes control bits arrive as synchronous levels, and that software reads
  pulse readErr/readBuf as single-cycle strobes.
*/
// Overview of operation
// - Pins act as serial lines only when enabled
// - Start, 7/8 data LSB first, parity, stops
// - Even parity generate and check
// - Odd parity generate and check
// - Zero parity sends 0, never errors
// - No parity bit, no parity error
// - Power on idles output high
// - Send frame, pulse transmit-done after stop
// - Idle high until next byte written
// - Receive only after power then enable
// - Falling edge starts counter, recheck start low
// - Shift in, receive-done, buffer unless overrun
// - Parity error does not abort frame
// - Receiver checks a single stop bit
// - Any error flag raises receive-error pulse
// - Reading error status clears all flags
// - Parity, framing and overrun errors flagged
// - Input changes only when two samples agree
// - Bit rate is divider output halved
// - Power off resets serial logic asynchronously
// - Enables off reset circuits synchronously
`timescale 1ns/1ps
`default_nettype none
module asrte_serial_engine
(
  // Clock and reset
  input  wire logic                 clk,
  input  wire logic                 rstn,
  // Mode and baud configuration
  input  wire asrte_pkg::asrte_mode_s modeCfg,
  input  wire logic [1:0]           clockSourceSelect,
  input  wire logic [4:0]           divisorSelectField,
  input  wire logic                 extBaseTick,
  // Transmit write
  input  wire logic                 txWrite,
  input  wire logic [7:0]           txData,
  // Receive reads
  input  wire logic                 readErr,
  input  wire logic                 readBuf,
  // Pins
  input  wire logic                 serialInPin,
  output logic                      serialOutPin,
  output logic                      serialOutOe,
  output logic                      serialInSel,
  // Register views
  output logic [7:0]                receiveBufferRegister,
  output asrte_pkg::asrte_err_s     receiveErrorStatus,
  output logic                      txBusy,
  // Interrupt pulses
  output logic                      transmitDoneIrq,
  output logic                      receiveDoneIrq,
  output logic                      receiveErrorIrq
);
  typedef enum {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP} asrte_tx_e;
  typedef enum {RX_IDLE, RX_CHECK, RX_DATA, RX_PAR, RX_STOP} asrte_rx_e;

  logic       powerOn;           // Unit power, acts as async reset too
  logic       unitRstn;          // Combined reset
  logic [5:0] pre_r;             // Prescaler
  logic       baseTick;          // Base clock enable
  logic [1:0] armCnt_r;          // Base ticks since transmit enable
  logic [4:0] txCnt_r;           // Transmit baud counter
  logic       txHalf_r;          // Halves counter output
  logic       txBitTick;
  asrte_tx_e  txState_r;
  logic [7:0] txShift_r;         // Transmit shift register
  logic [3:0] txBits_r;
  logic       txPar_r;
  logic       txStop2_r;
  logic [1:0] flt_r;             // Noise filter samples
  logic       rxFilt_r;          // Filtered input
  logic       rxFiltD_r;
  logic       rxFall;
  logic       rxOn;
  logic [4:0] rxCnt_r;           // Receive baud counter
  logic       rxHalf_r;
  logic       rxHalfTick;
  logic       rxBitTick;
  asrte_rx_e  rxState_r;
  logic [7:0] rxShift_r;         // Receive shift register
  logic [3:0] rxBits_r;
  logic       rxParAcc_r;
  logic       rxParErr_r;
  logic       bufFull_r;         // Buffer unread
  logic       pushValid;
  logic       pushReady;
  asrte_pkg::asrte_rxword_s pushWord;
  asrte_pkg::asrte_rxword_s popWord;
  logic       popValid;
  logic       popReady;
  logic [3:0] charLen;
  logic       txOn;
  logic       txAccept;          // Write taken: idle and armed

  assign powerOn  = modeCfg.powerOn;
  assign unitRstn = rstn && powerOn;
  assign txOn     = modeCfg.txEnable;
  assign rxOn     = modeCfg.rxEnable;
  assign charLen  = modeCfg.charLen8 ? asrte_pkg::ASRTE_LEN8 : asrte_pkg::ASRTE_LEN7;
  // A write while busy must not restart the bit counter of the running frame
  assign txAccept = txWrite && (txState_r == TX_IDLE) && (armCnt_r == 2'(asrte_pkg::ASRTE_ARM_CYC));

  // Prescaler: divided base clocks stay still while power is off; the external tick passes through
  always_ff @(posedge clk or negedge unitRstn)
  begin
    if (!unitRstn)
      pre_r <= '0;
    else
      pre_r <= pre_r + 6'h01;
  end

  // Base clock select
  always_comb
  begin
    case (clockSourceSelect)
      asrte_pkg::ASRTE_SRC_EXT:   baseTick = extBaseTick;
      asrte_pkg::ASRTE_SRC_DIV4:  baseTick = (pre_r[1:0] == asrte_pkg::ASRTE_PRE_MASK4[1:0]);
      asrte_pkg::ASRTE_SRC_DIV16: baseTick = (pre_r[3:0] == asrte_pkg::ASRTE_PRE_MASK16[3:0]);
      default:                    baseTick = (pre_r == asrte_pkg::ASRTE_PRE_MASK64);
    endcase
  end

  // Transmit baud: k base ticks per half bit, two halves per bit
  always_ff @(posedge clk or negedge unitRstn)
  begin
    if (!unitRstn)
    begin
      txCnt_r  <= '0;
      txHalf_r <= 1'b0;
    end
    else if (!txOn || txAccept)
    begin
      txCnt_r  <= '0;
      txHalf_r <= 1'b0;
    end
    else if (baseTick)
    begin
      if (txCnt_r + 5'h01 >= divisorSelectField)
      begin
        txCnt_r  <= '0;
        txHalf_r <= ~txHalf_r;
      end
      else
        txCnt_r <= txCnt_r + 5'h01;
    end
  end
  assign txBitTick = baseTick && txHalf_r && (txCnt_r + 5'h01 >= divisorSelectField);

  // Arming delay: a write before two base ticks is ignored, not half-sent
  always_ff @(posedge clk or negedge unitRstn)
  begin
    if (!unitRstn)
      armCnt_r <= '0;
    else if (!txOn)
      armCnt_r <= '0;
    else if (baseTick && armCnt_r != 2'(asrte_pkg::ASRTE_ARM_CYC))
      armCnt_r <= armCnt_r + 2'h1;
  end

  // Transmit sequencer
  always_ff @(posedge clk or negedge unitRstn)
  begin
    if (!unitRstn)
    begin
      txState_r       <= TX_IDLE;
      txShift_r       <= '0;
      txBits_r        <= '0;
      txPar_r         <= 1'b0;
      txStop2_r       <= 1'b0;
      serialOutPin    <= 1'b1;
      transmitDoneIrq <= 1'b0;
    end
    else if (!txOn)
    begin
      txState_r       <= TX_IDLE;
      txBits_r        <= '0;
      serialOutPin    <= 1'b1;
      transmitDoneIrq <= 1'b0;
    end
    else
    begin
      transmitDoneIrq <= 1'b0;
      case (txState_r)
        TX_IDLE:
        begin
          serialOutPin <= 1'b1;
          if (txAccept)
          begin
            txShift_r <= txData;
            txState_r <= TX_START;
            serialOutPin <= 1'b0;
            txStop2_r <= modeCfg.twoStop;
            // Even: 1 for odd count; odd: inverse; zero: always 0
            case (modeCfg.parityMode)
              asrte_pkg::ASRTE_PAR_EVEN: txPar_r <= ^(modeCfg.charLen8 ? txData : {1'b0, txData[6:0]});
              asrte_pkg::ASRTE_PAR_ODD:  txPar_r <= ~^(modeCfg.charLen8 ? txData : {1'b0, txData[6:0]});
              default:                   txPar_r <= 1'b0;
            endcase
          end
        end
        TX_START:
          if (txBitTick)
          begin
            serialOutPin <= txShift_r[0];
            txShift_r    <= txShift_r >> 1;
            txBits_r     <= 4'h1;
            txState_r    <= TX_DATA;
          end
        TX_DATA:
          if (txBitTick)
          begin
            if (txBits_r == charLen)
            begin
              if (modeCfg.parityMode == asrte_pkg::ASRTE_PAR_NONE)
              begin
                serialOutPin <= 1'b1;
                txState_r    <= TX_STOP;
              end
              else
              begin
                serialOutPin <= txPar_r;
                txState_r    <= TX_PAR;
              end
            end
            else
            begin
              serialOutPin <= txShift_r[0];
              txShift_r    <= txShift_r >> 1;
              txBits_r     <= txBits_r + 4'h1;
            end
          end
        TX_PAR:
          if (txBitTick)
          begin
            serialOutPin <= 1'b1;
            txState_r    <= TX_STOP;
          end
        TX_STOP:
          if (txBitTick)
          begin
            if (txStop2_r)
              txStop2_r <= 1'b0;
            else
            begin
              transmitDoneIrq <= 1'b1;
              txState_r       <= TX_IDLE;
            end
          end
        default:
          txState_r <= TX_IDLE;
      endcase
    end
  end

  // Pin ownership and busy flag
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      serialOutOe <= 1'b0;
      serialInSel <= 1'b0;
      txBusy      <= 1'b0;
    end
    else
    begin
      serialOutOe <= powerOn && txOn;
      serialInSel <= powerOn && rxOn;
      txBusy      <= powerOn && txOn && (txState_r != TX_IDLE);
    end
  end

  // Noise filter: input forced high while power is off
  always_ff @(posedge clk or negedge unitRstn)
  begin
    if (!unitRstn)
    begin
      flt_r     <= 2'h3;
      rxFilt_r  <= 1'b1;
      rxFiltD_r <= 1'b1;
    end
    else if (baseTick)
    begin
      flt_r <= {flt_r[0], serialInPin};
      if (flt_r[1] == flt_r[0])
        rxFilt_r <= flt_r[0];
      rxFiltD_r <= rxFilt_r;
    end
  end
  assign rxFall = baseTick && rxFiltD_r && !rxFilt_r;

  // Receive baud counter, runs only inside a frame
  always_ff @(posedge clk or negedge unitRstn)
  begin
    if (!unitRstn)
    begin
      rxCnt_r  <= '0;
      rxHalf_r <= 1'b0;
    end
    else if (!rxOn || rxState_r == RX_IDLE)
    begin
      rxCnt_r  <= '0;
      rxHalf_r <= 1'b0;
    end
    else if (baseTick)
    begin
      if (rxCnt_r + 5'h01 >= divisorSelectField)
      begin
        rxCnt_r  <= '0;
        // Start check restarts the bit phase so later samples land mid bit
        rxHalf_r <= (rxState_r == RX_CHECK) ? 1'b0 : ~rxHalf_r;
      end
      else
        rxCnt_r <= rxCnt_r + 5'h01;
    end
  end
  // First half-period lands mid start bit; later full periods land mid bit
  assign rxHalfTick = baseTick && (rxCnt_r + 5'h01 >= divisorSelectField);
  assign rxBitTick  = rxHalfTick && rxHalf_r;

  // Receive sequencer
  always_ff @(posedge clk or negedge unitRstn)
  begin
    if (!unitRstn)
    begin
      rxState_r  <= RX_IDLE;
      rxShift_r  <= '0;
      rxBits_r   <= '0;
      rxParAcc_r <= 1'b0;
      rxParErr_r <= 1'b0;
      pushValid  <= 1'b0;
      pushWord   <= '0;
    end
    else if (!rxOn)
    begin
      rxState_r <= RX_IDLE;
      pushValid <= 1'b0;
    end
    else
    begin
      if (pushReady)
        pushValid <= 1'b0;
      case (rxState_r)
        RX_IDLE:
          if (rxFall)
            rxState_r <= RX_CHECK;
        RX_CHECK:
          if (rxHalfTick)
          begin
            if (!rxFilt_r)
            begin
              rxState_r  <= RX_DATA;
              rxBits_r   <= '0;
              rxParAcc_r <= 1'b0;
              rxParErr_r <= 1'b0;
            end
            else
              rxState_r <= RX_IDLE;
          end
        RX_DATA:
          if (rxBitTick)
          begin
            rxShift_r  <= {rxFilt_r, rxShift_r[7:1]};
            rxParAcc_r <= rxParAcc_r ^ rxFilt_r;
            rxBits_r   <= rxBits_r + 4'h1;
            if (rxBits_r + 4'h1 == charLen)
              rxState_r <= (modeCfg.parityMode == asrte_pkg::ASRTE_PAR_NONE) ? RX_STOP : RX_PAR;
          end
        RX_PAR:
          if (rxBitTick)
          begin
            // Error is noted, frame continues to the stop position
            case (modeCfg.parityMode)
              asrte_pkg::ASRTE_PAR_EVEN: rxParErr_r <= rxParAcc_r ^ rxFilt_r;
              asrte_pkg::ASRTE_PAR_ODD:  rxParErr_r <= ~(rxParAcc_r ^ rxFilt_r);
              default:                   rxParErr_r <= 1'b0;
            endcase
            rxState_r <= RX_STOP;
          end
        RX_STOP:
          if (rxBitTick)
          begin
            pushValid              <= 1'b1;
            pushWord.data          <= modeCfg.charLen8 ? rxShift_r : {1'b0, rxShift_r[7:1]};
            pushWord.err.parityErr <= rxParErr_r;
            pushWord.err.framingErr <= !rxFilt_r;
            pushWord.err.overrunErr <= bufFull_r;
            rxState_r              <= RX_IDLE;
          end
        default:
          rxState_r <= RX_IDLE;
      endcase
    end
  end

  // Word buffer between frame end and the visible registers
  asrte_skid_buf #(.WIDTH($bits(asrte_pkg::asrte_rxword_s))) uBuf
  (
    .clk      (clk),
    .rstn     (unitRstn),
    .clr      (!rxOn),
    .inValid  (pushValid),
    .inReady  (pushReady),
    .inData   (pushWord),
    .outValid (popValid),
    .outReady (popReady),
    .outData  (popWord)
  );
  assign popReady = 1'b1;

  // Visible buffer, error flags and receive interrupts
  always_ff @(posedge clk or negedge unitRstn)
  begin
    if (!unitRstn)
    begin
      receiveBufferRegister <= '0;
      receiveErrorStatus    <= '0;
      bufFull_r             <= 1'b0;
      receiveDoneIrq        <= 1'b0;
      receiveErrorIrq       <= 1'b0;
    end
    else
    begin
      receiveDoneIrq  <= 1'b0;
      receiveErrorIrq <= 1'b0;
      if (readBuf)
        bufFull_r <= 1'b0;
      if (readErr)
        receiveErrorStatus <= '0;
      if (popValid)
      begin
        // Set wins over a same-cycle read clear
        if (!popWord.err.overrunErr)
        begin
          receiveBufferRegister <= popWord.data;
          bufFull_r             <= 1'b1;
        end
        receiveDoneIrq <= 1'b1;
        if (|popWord.err)
        begin
          receiveErrorStatus <= popWord.err | (readErr ? 3'h0 : receiveErrorStatus);
          receiveErrorIrq    <= 1'b1;
        end
      end
    end
  end
endmodule // asrte_serial_engine
`default_nettype wire

// File: verif/asrte_serial_engine_sva.sv
/*
  Port checker for the serial engine, bound into every instance.
  Assumes the bench runs a bit time of at least 48 clocks.
*/
`timescale 1ns/1ps
`default_nettype none
module asrte_serial_engine_sva
(
  // Clock and reset
  input  wire logic                  clk,
  input  wire logic                  rstn,
  // Inputs watched
  input  wire asrte_pkg::asrte_mode_s modeCfg,
  input  wire logic                  txWrite,
  input  wire logic                  readErr,
  // Outputs watched
  input  wire logic                  serialOutPin,
  input  wire logic                  serialOutOe,
  input  wire logic                  serialInSel,
  input  wire asrte_pkg::asrte_err_s receiveErrorStatus,
  input  wire logic                  txBusy,
  input  wire logic                  transmitDoneIrq,
  input  wire logic                  receiveDoneIrq,
  input  wire logic                  receiveErrorIrq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  // Accepted write: armed long enough and idle
  sequence sWr;
    txWrite && !txBusy && modeCfg.powerOn && modeCfg.txEnable && $past(modeCfg.txEnable, 12);
  endsequence
  // Start bit held low
  sequence sLow;
    !serialOutPin [*8];
  endsequence
  // Pin ownership follows power and enable one cycle late, both ways
  a_out_select: assert property (serialOutOe == ($past(modeCfg.powerOn) && $past(modeCfg.txEnable)))
    else $error("output enable does not follow power and enable");
  a_in_select: assert property (serialInSel == ($past(modeCfg.powerOn) && $past(modeCfg.rxEnable)))
    else $error("input select does not follow power and enable");
  a_off_idle: assert property (!modeCfg.powerOn |-> serialOutPin && !txBusy && receiveErrorStatus == 3'h0)
    else $error("power off state wrong");
  a_tx_start: assert property (sWr |=> sLow)
    else $error("no start bit after write");
  a_done_stop: assert property (transmitDoneIrq |-> serialOutPin && $past(serialOutPin, 40))
    else $error("done before stop bit ended");
  a_idle_high: assert property ($fell(txBusy) |-> serialOutPin [*8])
    else $error("line not idle after frame");
  a_err_irq: assert property (receiveErrorIrq |-> receiveErrorStatus != 3'h0)
    else $error("error pulse without flag");
  a_err_clear: assert property (readErr ##1 !receiveDoneIrq |-> receiveErrorStatus == 3'h0)
    else $error("flags kept after read");
  a_par_mode: assert property ($rose(receiveErrorStatus.parityErr) |-> modeCfg.parityMode[1])
    else $error("parity error in unchecked mode");
endmodule // asrte_serial_engine_sva
bind asrte_serial_engine asrte_serial_engine_sva chk (.clk(clk), .rstn(rstn), .modeCfg(modeCfg),
  .txWrite(txWrite), .readErr(readErr), .serialOutPin(serialOutPin), .serialOutOe(serialOutOe),
  .serialInSel(serialInSel), .receiveErrorStatus(receiveErrorStatus), .txBusy(txBusy),
  .transmitDoneIrq(transmitDoneIrq), .receiveDoneIrq(receiveDoneIrq), .receiveErrorIrq(receiveErrorIrq));
`default_nettype wire

// File: verif/asrte_uart_peer.sv
/*
  Remote serial partner: sends frames into the engine, captures its output.
  Assumes BITC clocks per bit on both lines.
*/
`timescale 1ns/1ps
`default_nettype none
module asrte_uart_peer
#(
  parameter int BITC = 64  // Clocks per bit
)
(
  // Clock
  input  wire logic        clk,
  // Engine output line
  input  wire logic        serialOutPin,
  input  wire logic        serialOutOe,
  // Engine input line and captures
  output var  logic        line,
  output var  logic [11:0] txBits,
  output var  logic        txGot
);
  // Line idles high between frames
  initial
  begin
    line = 1'b1;
    txBits = 12'h000;
    txGot = 1'b0;
  end
  // Twelve bit times, LSB first; unused tail is idle ones
  task automatic send(logic [11:0] v);
    for (int b = 0; b < 12; b++)
    begin
      @(posedge clk);
      line <= v[b];
      repeat (BITC - 1) @(posedge clk);
    end
    @(posedge clk);
    line <= 1'b1;
  endtask
  // Short low pulse, then quiet long enough for any frame
  task automatic glitch(int n);
    @(posedge clk);
    line <= 1'b0;
    repeat (n) @(posedge clk);
    line <= 1'b1;
    repeat (BITC * 12) @(posedge clk);
  endtask
  // Mid-bit sampling keeps clear of edge races
  always @(negedge serialOutPin)
  begin
    if (serialOutOe === 1'b1)
    begin
      repeat (BITC / 2) @(posedge clk);
      for (int b = 0; b < 12; b++)
      begin
        txBits[b] <= serialOutPin;
        repeat (BITC) @(posedge clk);
      end
      txGot <= 1'b1;
      @(posedge clk);
      txGot <= 1'b0;
    end
  end
endmodule // asrte_uart_peer
`default_nettype wire

// File: verif/asrte_serial_engine_tb_top.sv
/*
  Self-checking bench for the serial engine, queued notes per direction.
  Assumes the peer model and the bound checker.
*/
`timescale 1ns/1ps
`default_nettype none
module asrte_serial_engine_tb_top;
  localparam int BITC = 64;  // 2*k base ticks of 4 clocks, k = 8
  logic clk, rstn, txWrite, readErr, readBuf, sIn, sOut, sOe, sSel, txBusy, tDone, rDone, rErr, txGot;
  logic [7:0] txData, rBuf;
  logic [11:0] txBits, e12;
  logic [10:0] e11;
  logic [31:0] seed;
  logic [1:0] src, ec;  // Base clock source and external tick phase
  asrte_pkg::asrte_mode_s m;
  asrte_pkg::asrte_err_s rSt;
  logic [11:0] txq[$];  // Expected line bits
  logic [10:0] rxq[$];  // Expected word and flags
  int bad_count, n_tests, i, j, w;
  asrte_serial_engine dut (.clk(clk), .rstn(rstn), .modeCfg(m), .clockSourceSelect(src),
    .divisorSelectField(asrte_pkg::ASRTE_DIV_MIN), .extBaseTick(ec == 2'h3), .txWrite(txWrite), .txData(txData),
    .readErr(readErr), .readBuf(readBuf), .serialInPin(sIn), .serialOutPin(sOut), .serialOutOe(sOe),
    .serialInSel(sSel), .receiveBufferRegister(rBuf), .receiveErrorStatus(rSt), .txBusy(txBusy),
    .transmitDoneIrq(tDone), .receiveDoneIrq(rDone), .receiveErrorIrq(rErr));
  asrte_uart_peer #(.BITC(BITC)) peer (.clk(clk), .serialOutPin(sOut), .serialOutOe(sOe), .line(sIn),
    .txBits(txBits), .txGot(txGot));
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // External base tick every fourth clock, same bit time as the divide-by-4 source
  always @(posedge clk) ec <= ec + 2'h1;
  function automatic logic [31:0] lf(logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // Frame bits for the current mode, idle ones after the stops
  function automatic logic [11:0] fr(logic [7:0] d);
    logic [11:0] v;
    logic p;
    int n;
    v = 12'hFFE;
    n = m.charLen8 ? 8 : 7;
    p = ^(d & (m.charLen8 ? 8'hFF : 8'h7F));
    for (int b = 0; b < n; b++) v[1 + b] = d[b];
    if (m.parityMode == asrte_pkg::ASRTE_PAR_EVEN) v[1 + n] = p;
    if (m.parityMode == asrte_pkg::ASRTE_PAR_ODD) v[1 + n] = ~p;
    if (m.parityMode == asrte_pkg::ASRTE_PAR_ZERO) v[1 + n] = 1'b0;
    return v;
  endfunction
  task automatic chk(logic ok, string s);
    n_tests++;
    if (ok !== 1'b1)
    begin
      bad_count++;
      $display("wrong value at %0t: %s", $time, s);
    end
  endtask
  task automatic results();
    $display("checks %0d, mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // Status read always precedes the buffer read
  task automatic rdAll();
    @(posedge clk);
    readErr <= 1'b1;
    @(posedge clk);
    readErr <= 1'b0;
    readBuf <= 1'b1;
    @(posedge clk);
    readBuf <= 1'b0;
  endtask
  task automatic txOne(logic [7:0] d);
    txq.push_back(fr(d));
    @(posedge clk);
    txWrite <= 1'b1;
    txData <= d;
    @(posedge clk);
    txWrite <= 1'b0;
    for (w = 0; w < 1000 && tDone !== 1'b1; w++) @(negedge clk);
    chk(w < 1000, "no transmit done");
    if (w >= 1000) results();
    repeat (BITC) @(posedge clk);
  endtask
  // Flip hits parity, or the stop bit when there is no parity
  task automatic rxFrame(logic [7:0] d, logic flip);
    logic [11:0] v;
    logic [2:0] er;
    int n;
    n = m.charLen8 ? 8 : 7;
    v = fr(d);
    er = 3'h0;
    if (flip)
    begin
      v[1 + n] = ~v[1 + n];
      er = m.parityMode[1] ? 3'h4 : {1'b0, m.parityMode == asrte_pkg::ASRTE_PAR_NONE, 1'b0};
    end
    rxq.push_back({d & (m.charLen8 ? 8'hFF : 8'h7F), er});
    peer.send(v);
    rdAll();
  endtask
  // Result watcher: oldest note against each result
  always @(negedge clk)
  begin
    if (txGot === 1'b1)
    begin
      e12 = txq.size() ? txq.pop_front() : 12'hXXX;
      chk(txBits === e12, "tx frame");
    end
    if (rDone === 1'b1)
    begin
      e11 = rxq.size() ? rxq.pop_front() : 11'hXXX;
      chk({rBuf, rSt} === e11 && rErr === (|e11[2:0]), "rx word");
    end
  end
  initial
  begin
    {rstn, txWrite, readErr, readBuf, txData} = 12'h000;
    m = 7'h00;
    src = asrte_pkg::ASRTE_SRC_DIV4;
    ec = 2'h0;
    bad_count = 0;
    n_tests = 0;
    seed = 32'h00017D63;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    // Every parity mode, both lengths and stop counts
    for (i = 0; i < 4; i++)
    begin
      @(posedge clk);
      m <= '{1'b1, 1'b0, 1'b0, i[1:0], i[0], i[1]};
      src <= i[0] ? asrte_pkg::ASRTE_SRC_EXT : asrte_pkg::ASRTE_SRC_DIV4;
      repeat (4) @(posedge clk);
      m.txEnable <= 1'b1;
      m.rxEnable <= 1'b1;
      repeat (12) @(posedge clk);
      for (j = 0; j < 2; j++)
      begin
        seed = lf(seed);
        txOne(seed[7:0]);
        rxFrame(seed[15:8], j[0]);
      end
    end
    // Unread word: second frame is dropped and flagged
    rxq.push_back({8'h3C, 3'h0});
    peer.send(fr(8'h3C));
    rxq.push_back({8'h3C, 3'h1});
    peer.send(fr(8'hC3));
    rdAll();
    rxFrame(8'h5A, 1'b0);
    peer.glitch(16);
    peer.glitch(3);
    @(posedge clk);
    m.rxEnable <= 1'b0;
    peer.send(fr(8'h81));
    @(posedge clk);
    m.powerOn <= 1'b0;
    repeat (8) @(posedge clk);
    chk(sOut === 1'b1 && rSt === 3'h0 && rBuf === 8'h00, "power off");
    chk(txq.size() == 0 && rxq.size() == 0, "results missing");
    results();
  end
endmodule // asrte_serial_engine_tb_top
`default_nettype wire
